//--- tcisp_pkg.sv
package tcisp_pkg;

  localparam logic [7:0]  ADDR_W_PAIR0 = 8'hba;
  localparam logic [7:0]  ADDR_W_PAIR1 = 8'h28;
  localparam logic [15:0] PTR_RST      = 16'h0000;
  localparam logic [3:0]  ACK_BIT      = 4'h8;
  localparam int          CLK_HZ       = 200000000;
  localparam int          BUS_HZ       = 400000;
  localparam int          QTR_CYC      = CLK_HZ / (4 * BUS_HZ);

  // write form of the selected pair; read form sets bit 0
  function automatic logic [7:0] pair_addr(input logic sel);
    pair_addr = sel ? ADDR_W_PAIR1 : ADDR_W_PAIR0;
  endfunction : pair_addr

endpackage : tcisp_pkg

//--- tcisp_if.sv
`timescale 1ns/1ps
interface tcisp_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic addr_sel;
  logic init_done;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (d_sda_oe ? d_sda_o : 1'b1);

  modport dev (
    input  scl,
    input  sda,
    input  addr_sel,
    input  init_done,
    output d_sda_o,
    output d_sda_oe
  );

  modport host (
    input  scl,
    input  sda,
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    output addr_sel,
    output init_done
  );
endinterface : tcisp_if

//--- tcisp_dev.sv
`timescale 1ns/1ps
module tcisp_dev (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  tcisp_if.dev             bus,
  output logic             wr_valid,
  output logic [15:0]      wr_addr,
  output logic [7:0]       wr_data,
  output logic [15:0]      rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             rd_strobe
);

  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} tcisp_dst_t;

  typedef struct packed {
    tcisp_dst_t  st;
    logic        scl;
    logic        sda;
    logic [7:0]  sh;
    logic [3:0]  cnt;
    logic [1:0]  phase;
    logic        rw;
    logic        mack;
    logic [15:0] ptr;
    logic        sda_oe;
    logic        sel;
    logic        cfg;
    logic        wr_valid;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        rd_strobe;
  } tcisp_dstate_t;

  tcisp_dstate_t q;
  tcisp_dstate_t d;
  logic          rise;
  logic          fall;
  logic          start;
  logic          stop;
  logic          load;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d           = q;
    load        = 1'b0;
    d.scl       = bus.scl;
    d.sda       = bus.sda;
    d.wr_valid  = 1'b0;
    d.rd_strobe = 1'b0;
    rise  = bus.scl & ~q.scl;
    fall  = ~bus.scl & q.scl;
    start = bus.scl & q.scl & q.sda & ~bus.sda;
    stop  = bus.scl & q.scl & ~q.sda & bus.sda;
    if (!q.cfg && bus.init_done) begin
      d.cfg = 1'b1;
      d.sel = bus.addr_sel;
    end
    // deaf until the pair is fixed; never drives scl, never starts
    if (!q.cfg) begin
      d.st = D_IDLE;
    end else if (start) begin
      d.st     = D_RX;
      d.cnt    = 4'h0;
      d.phase  = 2'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.st     = D_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      unique case (q.st)
        D_IDLE: begin
        end
        D_RX: begin
          if (rise) begin
            d.sh  = {q.sh[6:0], bus.sda};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == tcisp_pkg::ACK_BIT) begin
            d.cnt    = 4'h0;
            d.st     = D_ACK;
            d.sda_oe = 1'b1;
            unique case (q.phase)
              2'h0: begin
                if ((q.sh | 8'h01) != (tcisp_pkg::pair_addr(q.sel) | 8'h01)) begin
                  d.st     = D_IDLE;
                  d.sda_oe = 1'b0;
                end else begin
                  d.rw    = q.sh[0];
                  d.phase = 2'h1;
                end
              end
              2'h1: begin
                d.ptr[15:8] = q.sh;
                d.phase     = 2'h2;
              end
              2'h2: begin
                d.ptr[7:0] = q.sh;
                d.phase    = 2'h3;
              end
              2'h3: begin
                d.wr_valid = 1'b1;
                d.wr_addr  = q.ptr;
                d.wr_data  = q.sh;
                d.ptr      = q.ptr + 16'h0001;
              end
            endcase
          end
        end
        D_ACK: begin
          if (fall) begin
            if (q.rw) begin
              load = 1'b1;
            end else begin
              d.sda_oe = 1'b0;
              d.st     = D_RX;
            end
          end
        end
        D_TX: begin
          if (fall) begin
            if (q.cnt == tcisp_pkg::ACK_BIT) begin
              d.sda_oe = 1'b0;
              d.st     = D_TXACK;
            end else begin
              d.sda_oe = ~q.sh[6];
              d.sh     = {q.sh[6:0], 1'b0};
              d.cnt    = q.cnt + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (rise) begin
            d.mack = ~bus.sda;
          end else if (fall) begin
            if (q.mack) begin
              load = 1'b1;
            end else begin
              d.st = D_IDLE;
            end
          end
        end
      endcase
    end
    // rd_data is taken in this cycle, while rd_addr still shows the pointer
    if (load) begin
      d.sh        = rd_data;
      d.sda_oe    = ~rd_data[7];
      d.cnt       = 4'h1;
      d.st        = D_TX;
      d.rd_strobe = 1'b1;
      d.ptr       = q.ptr + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q       <= '0;
      q.st    <= D_IDLE;
      q.scl   <= 1'b1;
      q.sda   <= 1'b1;
      q.ptr   <= tcisp_pkg::PTR_RST;
    end else begin
      q <= d;
    end
  end

  assign bus.d_sda_o  = 1'b0;
  assign bus.d_sda_oe = q.sda_oe;
  assign wr_valid     = q.wr_valid;
  assign wr_addr      = q.wr_addr;
  assign wr_data      = q.wr_data;
  assign rd_addr      = q.ptr;
  assign rd_strobe    = q.rd_strobe;

endmodule : tcisp_dev

//--- tcisp_host.sv
`timescale 1ns/1ps
module tcisp_host #(
  parameter int QTR_CYC = tcisp_pkg::QTR_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  tcisp_if.host            bus,
  input  wire logic        pair_sel,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_rd,
  input  wire logic [15:0] cmd_reg,
  input  wire logic [7:0]  cmd_len,
  output logic             cmd_ready,
  input  wire logic [7:0]  wr_data,
  output logic             wr_take,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             done,
  output logic             nack_err
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} tcisp_hst_t;

  typedef struct packed {
    tcisp_hst_t  st;
    logic [15:0] tick;
    logic [1:0]  qtr;
    logic [3:0]  bitn;
    logic [2:0]  step;
    logic        rd;
    logic [15:0] rg;
    logic [7:0]  left;
    logic [7:0]  sh;
    logic        mack;
    logic        scl_oe;
    logic        sda_oe;
    logic        sel;
    logic        init;
    logic        ready;
    logic        wr_take;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        done;
    logic        nack;
  } tcisp_hstate_t;

  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

  tcisp_hstate_t q;
  tcisp_hstate_t d;
  logic          qend;
  logic          load;
  logic [2:0]    nstep;
  logic [7:0]    tb;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d          = q;
    load       = 1'b0;
    nstep      = q.step;
    tb         = 8'h00;
    d.wr_take  = 1'b0;
    d.rd_valid = 1'b0;
    d.done     = 1'b0;
    d.init     = 1'b1;
    // pair strap caught on the first clocked cycle after release
    if (!q.init) begin
      d.sel = pair_sel;
    end
    qend       = (q.tick == QTR_LAST);
    if (q.st != H_IDLE) begin
      d.tick = qend ? 16'h0000 : q.tick + 16'h0001;
      if (qend) begin
        d.qtr = q.qtr + 2'h1;
      end
    end
    unique case (q.st)
      H_IDLE: begin
        d.ready = q.init;
        if (q.ready && cmd_valid) begin
          d.ready  = 1'b0;
          d.rd     = cmd_rd;
          d.rg     = cmd_reg;
          d.left   = cmd_len;
          d.nack   = 1'b0;
          d.step   = 3'h0;
          d.tick   = 16'h0000;
          d.qtr    = 2'h0;
          d.st     = H_START;
        end
      end
      H_START: begin
        if (qend) begin
          unique case (q.qtr)
            2'h0: d.scl_oe = 1'b0;
            2'h1: d.sda_oe = 1'b1;
            2'h2: d.scl_oe = 1'b1;
            2'h3: load     = 1'b1;
          endcase
        end
      end
      H_BYTE: begin
        if (qend) begin
          unique case (q.qtr)
            2'h0: d.scl_oe = 1'b0;
            2'h1: begin
            end
            2'h2: begin
              d.scl_oe = 1'b1;
              if (q.bitn == tcisp_pkg::ACK_BIT) begin
                d.mack = ~bus.sda;
              end else begin
                d.sh = {q.sh[6:0], bus.sda};
              end
            end
            2'h3: begin
              if (q.bitn != tcisp_pkg::ACK_BIT) begin
                d.bitn = q.bitn + 4'h1;
                if (q.step == 3'h5) begin
                  // ack every byte but the last
                  d.sda_oe = (q.bitn == 4'h7) && (q.left != 8'h01);
                end else begin
                  d.sda_oe = (q.bitn != 4'h7) && ~q.sh[7];
                end
              end else if (q.step == 3'h5) begin
                d.rd_data  = q.sh;
                d.rd_valid = 1'b1;
                d.left     = q.left - 8'h01;
                if (q.left == 8'h01) begin
                  d.st     = H_STOP;
                  d.sda_oe = 1'b1;
                end else begin
                  load = 1'b1;
                end
              end else if (!q.mack) begin
                d.nack   = 1'b1;
                d.st     = H_STOP;
                d.sda_oe = 1'b1;
              end else begin
                unique case (q.step)
                  3'h0: begin
                    nstep = 3'h1;
                    load  = 1'b1;
                  end
                  3'h1: begin
                    nstep = 3'h2;
                    load  = 1'b1;
                  end
                  3'h2: begin
                    if (q.rd) begin
                      d.step   = 3'h4;
                      d.st     = H_START;
                      d.sda_oe = 1'b0;
                    end else begin
                      nstep = 3'h3;
                      load  = 1'b1;
                    end
                  end
                  3'h3: begin
                    d.left = q.left - 8'h01;
                    if (q.left == 8'h01) begin
                      d.st     = H_STOP;
                      d.sda_oe = 1'b1;
                    end else begin
                      load = 1'b1;
                    end
                  end
                  default: begin
                    nstep = 3'h5;
                    load  = 1'b1;
                  end
                endcase
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (qend) begin
          unique case (q.qtr)
            2'h0: d.scl_oe = 1'b0;
            2'h1: d.sda_oe = 1'b0;
            2'h2: begin
            end
            2'h3: begin
              d.st    = H_IDLE;
              d.done  = 1'b1;
              d.ready = 1'b1;
            end
          endcase
        end
      end
    endcase
    if (load) begin
      unique case (nstep)
        3'h0:    tb = tcisp_pkg::pair_addr(q.sel);
        3'h1:    tb = q.rg[15:8];
        3'h2:    tb = q.rg[7:0];
        3'h3:    tb = wr_data;
        3'h4:    tb = tcisp_pkg::pair_addr(q.sel) | 8'h01;
        default: tb = 8'hff;
      endcase
      d.st      = H_BYTE;
      d.step    = nstep;
      d.bitn    = 4'h0;
      d.sh      = tb;
      d.sda_oe  = (nstep != 3'h5) && ~tb[7];
      d.wr_take = (nstep == 3'h3);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q    <= '0;
      q.st <= H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign bus.m_scl_o   = 1'b0;
  assign bus.m_sda_o   = 1'b0;
  assign bus.m_scl_oe  = q.scl_oe;
  assign bus.m_sda_oe  = q.sda_oe;
  assign bus.addr_sel  = q.sel;
  assign bus.init_done = q.init;
  assign cmd_ready     = q.ready;
  assign wr_take       = q.wr_take;
  assign rd_data       = q.rd_data;
  assign rd_valid      = q.rd_valid;
  assign done          = q.done;
  assign nack_err      = q.nack;

endmodule : tcisp_host

//--- tcisp_monitor.sv
`timescale 1ns/1ps
module tcisp_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_sda_oe,
  input wire logic d_sda_oe,
  input wire logic init_done
);
  logic       scl_q, sda_q, rd_q;
  logic [3:0] bits;
  logic [7:0] byten;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // bit and byte position since the last start
  always_ff @(posedge clk_sys) begin
    scl_q <= scl;
    sda_q <= sda;
    if (rst || (scl && scl_q && sda_q && !sda)) begin
      bits  <= 4'h0;
      byten <= 8'h00;
      rd_q  <= rst ? 1'b0 : rd_q;
    end else if (scl && !scl_q) begin
      bits  <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
      byten <= (bits == 4'h8) ? byten + 8'h01 : byten;
      if (bits == 4'h7 && byten == 8'h00) rd_q <= sda;
    end
  end

  ////////////////////////////////////////
  a_ack_write: assert property (
    $rose(scl) && bits == 4'h8 && (byten == 8'h00 || !rd_q) |-> !sda)
    else $error("device ack missing");
  a_dev_change_low: assert property (
    $changed(d_sda_oe) |-> !scl) else $error("device sda changed with scl high");
  a_drive_prompt: assert property (
    $rose(d_sda_oe) |-> ##[1:12] $rose(scl)) else $error("device drive not followed by a pulse");
  a_nack_release: assert property (
    $rose(scl) && bits == 4'h8 && rd_q && byten != 8'h00 && sda |-> !d_sda_oe [*8])
    else $error("device drove after nack");
  a_master_ack_free: assert property (
    $rose(scl) && bits == 4'h8 && rd_q && byten != 8'h00 |-> !d_sda_oe)
    else $error("device drove in master ack slot");
  a_idle_before_init: assert property (
    !init_done |-> !d_sda_oe) else $error("device drove before init");
  a_stop_release: assert property (
    scl && $past(scl) && $rose(sda) |-> !d_sda_oe [*4]) else $error("device drove after stop");
  a_scl_low_bound: assert property (
    $fell(scl) |-> ##[2:24] $rose(scl)) else $error("scl held low too long");
  a_host_hold_high: assert property (
    $rose(scl) |=> $stable(m_sda_oe) [*3]) else $error("host sda moved early in scl high");
endmodule : tcisp_monitor

//--- touch_ctrl_i2c_slave_port_bench.sv
`timescale 1ns/1ps
module touch_ctrl_i2c_slave_port_bench;
  typedef struct packed {logic rd; logic [15:0] rg; logic [7:0] ln;} tcisp_row_t;
  localparam tcisp_row_t ROWS [5] = '{'{1'b0, 16'h8040, 8'h03}, '{1'b1, 16'h00fe, 8'h04},
    '{1'b1, 16'h1234, 8'h01}, '{1'b0, 16'hffff, 8'h02}, '{1'b0, 16'h0000, 8'h01}};
  logic        clk_sys, rst, pair_sel, cmd_valid, cmd_rd, cmd_ready, wr_take, rd_valid;
  logic        done, nack_err, wr_valid, rd_strobe, a;
  logic [15:0] cmd_reg, wr_addr, rd_addr, e_adr, n_dw, n_rd, n_rs;
  logic [7:0]  cmd_len, wr_data, h_rd, d_wr, dev_rd, w_base, n_wr;
  int          n_fail, n_compared, cyc;
  tcisp_if bus ();
  tcisp_if b2 ();

  // register contents as seen by the device: a fixed map of the pointer
  function automatic logic [7:0] exp_rd(input logic [15:0] ad);
    exp_rd = ad[7:0] ^ ad[15:8] ^ 8'h3c;
  endfunction : exp_rd
  assign dev_rd = exp_rd(rd_addr);

  tcisp_host #(.QTR_CYC(4)) i_tcisp_host (.clk_sys(clk_sys), .rst(rst), .bus(bus.host),
    .pair_sel(pair_sel), .cmd_valid(cmd_valid), .cmd_rd(cmd_rd), .cmd_reg(cmd_reg),
    .cmd_len(cmd_len), .cmd_ready(cmd_ready), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(h_rd), .rd_valid(rd_valid), .done(done), .nack_err(nack_err));
  tcisp_dev i_tcisp_dev (.clk_sys(clk_sys), .rst(rst), .bus(bus.dev), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(d_wr), .rd_addr(rd_addr), .rd_data(dev_rd),
    .rd_strobe(rd_strobe));
  // second device, driven by hand to break the address rule
  tcisp_dev i_tcisp_dev_b (.clk_sys(clk_sys), .rst(rst), .bus(b2.dev), .wr_valid(),
    .wr_addr(), .wr_data(), .rd_addr(), .rd_data(8'h00), .rd_strobe());
  tcisp_monitor i_tcisp_monitor (.clk_sys(clk_sys), .rst(rst), .scl(bus.scl), .sda(bus.sda),
    .m_sda_oe(bus.m_sda_oe), .d_sda_oe(bus.d_sda_oe), .init_done(bus.init_done));

  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict();
    if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  task automatic run(input logic rd, input logic [15:0] rg, input logic [7:0] ln);
    int t;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    e_adr = rg;
    w_base = rg[7:0] + 8'h11;
    {n_dw, n_rd, n_rs, n_wr} = '0;
    {cmd_rd, cmd_reg, cmd_len, cmd_valid} = {rd, rg, ln, 1'b1};
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 4000) begin
      @(negedge clk_sys);
      t++;
    end
    check({15'h0, done}, 16'h1);
    check({15'h0, nack_err}, 16'h0);
    check(rd ? n_rd : n_dw, {8'h00, ln});
    if (rd) check(n_rs, {8'h00, ln});
    check({8'h00, n_wr}, rd ? 16'h0000 : {8'h00, ln});
    check(rd_addr, rg + {8'h00, ln});
  endtask : run

  // raw master on the second bus: start, eight bits, ack slot, stop
  task automatic bang(input logic [7:0] v, output logic ack);
    b2.m_sda_oe = 1'b1;
    repeat (4) @(negedge clk_sys);
    b2.m_scl_oe = 1'b1;
    for (int i = 8; i >= 0; i--) begin
      repeat (4) @(negedge clk_sys);
      b2.m_sda_oe = (i > 0) ? !v[i - 1] : 1'b0;
      repeat (4) @(negedge clk_sys);
      b2.m_scl_oe = 1'b0;
      repeat (4) @(negedge clk_sys);
      ack = b2.sda;
      repeat (4) @(negedge clk_sys);
      b2.m_scl_oe = 1'b1;
    end
    b2.m_sda_oe = 1'b1;
    repeat (4) @(negedge clk_sys);
    b2.m_scl_oe = 1'b0;
    repeat (4) @(negedge clk_sys);
    b2.m_sda_oe = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask : bang

  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  always @(negedge clk_sys) begin
    if (wr_take === 1'b1) n_wr++;
    wr_data = w_base + n_wr;
    if (wr_valid === 1'b1) begin
      check(wr_addr, e_adr + n_dw);
      check({8'h00, d_wr}, {8'h00, w_base + n_dw[7:0]});
      n_dw++;
    end
    if (rd_valid === 1'b1) begin
      check({8'h00, h_rd}, {8'h00, exp_rd(e_adr + n_rd)});
      n_rd++;
    end
    if (rd_strobe === 1'b1) n_rs++;
  end

  initial begin
    {rst, pair_sel, cmd_valid, cmd_rd, cmd_reg, cmd_len, w_base, n_wr, wr_data} = {1'b1, 51'h0};
    {b2.m_scl_o, b2.m_sda_o, b2.m_scl_oe, b2.m_sda_oe, b2.addr_sel, b2.init_done} = 6'h00;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    b2.init_done = 1'b1;
    foreach (ROWS[i]) run(ROWS[i].rd, ROWS[i].rg, ROWS[i].ln);
    bang(8'h50, a);
    check({15'h0, a}, 16'h1);
    bang(tcisp_pkg::ADDR_W_PAIR0, a);
    check({15'h0, a}, 16'h0);
    // reset between runs, with the bus idle, and the other pair chosen
    rst = 1'b1;
    pair_sel = 1'b1;
    repeat (16) @(negedge clk_sys);
    check({14'h0, bus.scl, bus.sda}, 16'h3);
    rst = 1'b0;
    // one edge after release: init over, commands not yet taken
    @(negedge clk_sys);
    check({14'h0, bus.init_done, cmd_ready}, 16'h2);
    run(1'b0, 16'h0042, 8'h02);
    run(1'b1, 16'h0042, 8'h02);
    print_verdict();
  end
endmodule : touch_ctrl_i2c_slave_port_bench
